// [dv/pst_far_end.sv]
// far-end model: echoes the serial stream or sends a forced word
`timescale 1ns/1ps
`default_nettype none

module pst_far_end
   import pst_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic [WORD_W-1:0] tx_word_out,
   input  wire logic              serial_out_en,
   input  wire logic              force_en,
   input  wire logic [WORD_W-1:0] force_word,
   input  wire logic [WORD_W-1:0] err_mask,
   output logic [WORD_W-1:0]      rx_word_in
);
   // driver off leaves no valid level, so the line keeps toggling
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_word_in <= WORD_ZERO;
      end else if (force_en) begin
         rx_word_in <= force_word;
      end else if (serial_out_en) begin
         rx_word_in <= tx_word_out ^ err_mask;
      end else begin
         rx_word_in <= ~rx_word_in;
      end
   end
endmodule : pst_far_end

`default_nettype wire

// [dv/tb.sv]
// bench for the pattern self-test block
`timescale 1ns/1ps
`default_nettype none

module tb;
   import pst_pkg::*;
   logic              core_clk = 1'b0;
   logic              resetn = 1'b0;
   logic              test_reset_n = 1'b0;
   logic              force_en = 1'b0;
   pst_ctl_s          ctl = '0;
   logic [WORD_W-1:0] tx_data_in = WORD_ZERO;
   logic [WORD_W-1:0] force_word = WORD_ZERO;
   logic [WORD_W-1:0] err_mask = WORD_ZERO;
   logic [MV_W-1:0]   rx_amplitude_mv = '0;
   logic [WORD_W-1:0] rx_word_in, tx_word_out, rx_word_out;
   logic              serial_out_en, comma_or_pass_out, rx_half_rate_out;
   logic              signal_absent_flag, factory_test_active, scan_tap_in_reset;
   int                n_fail = 0;
   int                checked = 0;

   always #4 core_clk = ~core_clk;

   pst_self_test pst_self_test_i (.core_clk, .resetn, .ctl, .tx_data_in, .rx_word_in,
      .rx_amplitude_mv, .test_reset_n, .tx_word_out, .serial_out_en, .rx_word_out,
      .comma_or_pass_out, .rx_half_rate_out, .signal_absent_flag, .factory_test_active,
      .scan_tap_in_reset);
   pst_far_end pst_far_end_i (.core_clk, .resetn, .tx_word_out, .serial_out_en,
      .force_en, .force_word, .err_mask, .rx_word_in);

   task automatic chk_bit(string what, logic exp, logic got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_word(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // one edge, then let its updates settle
   task automatic smp;
      @(posedge core_clk);
      #1;
   endtask : smp

   task automatic t_pins;
      chk_bit("scan reset", 1'b1, scan_tap_in_reset);
      cyc(1);
      test_reset_n <= 1'b1;
      ctl.factory_test_select <= 1'b1;
      ctl.rx_clock_rate_select <= 1'b1;
      smp();
      chk_bit("scan reset", 1'b0, scan_tap_in_reset);
      chk_bit("factory", 1'b1, factory_test_active);
      chk_bit("half rate", 1'b1, rx_half_rate_out);
      cyc(1);
      ctl.factory_test_select <= 1'b0;
      ctl.pattern_test_select <= 1'b1;
      smp();
      chk_bit("factory", 1'b0, factory_test_active);
      chk_bit("half rate", 1'b0, rx_half_rate_out);
      cyc(1);
      ctl.pattern_test_select <= 1'b0;
      ctl.rx_clock_rate_select <= 1'b0;
      $display("done pins");
   endtask : t_pins

   task automatic t_normal;
      tx_data_in <= 10'h2a5;
      force_en <= 1'b1;
      force_word <= 10'h37c;
      cyc(1);
      force_word <= 10'h155;
      smp();
      chk_word("tx word", 10'h2a5, tx_word_out);
      chk_bit("serial en", 1'b1, serial_out_en);
      chk_word("rx word", 10'h37c, rx_word_out);
      chk_bit("comma mark", 1'b1, comma_or_pass_out);
      smp();
      chk_word("rx word", 10'h155, rx_word_out);
      chk_bit("comma mark", 1'b0, comma_or_pass_out);
      $display("done normal");
   endtask : t_normal

   task automatic t_loop;
      cyc(1);
      force_en <= 1'b0;
      ctl.internal_loop_select <= 1'b1;
      tx_data_in <= 10'h3c1;
      smp();
      chk_bit("serial en", 1'b0, serial_out_en);
      smp();
      chk_word("loop word", 10'h3c1, rx_word_out);
      cyc(1);
      ctl.internal_loop_select <= 1'b0;
      $display("done loop");
   endtask : t_loop

   task automatic t_prbs;
      logic [69:0] s;
      logic        bad;
      logic        low;
      bad = 1'b0;
      low = 1'b0;
      cyc(1);
      ctl.bus_width_select <= 1'b0;
      ctl.pattern_test_select <= 1'b1;
      // stream bit n must equal bit n-7 xor bit n-6
      for (int k = 0; k < 7; k++) begin
         @(posedge core_clk);
         tx_data_in <= WORD_W'(k * 77);
         #1;
         s[k*10 +: 10] = tx_word_out;
      end
      for (int n = 7; n < 70; n++) if (s[n] !== (s[n-7] ^ s[n-6])) bad = 1'b1;
      if (s === '0) bad = 1'b1;
      chk_bit("prbs stream", 1'b0, bad);
      cyc(4);
      smp();
      chk_bit("pass clean", 1'b1, comma_or_pass_out);
      cyc(1);
      err_mask <= 10'h010;
      cyc(1);
      err_mask <= WORD_ZERO;
      repeat (6) begin
         smp();
         if (comma_or_pass_out === 1'b0) low = 1'b1;
      end
      chk_bit("pass dip", 1'b1, low);
      cyc(8);
      smp();
      chk_bit("pass live", 1'b1, comma_or_pass_out);
      cyc(1);
      ctl.align_enable <= 1'b1;
      cyc(1);
      err_mask <= 10'h010;
      cyc(1);
      err_mask <= WORD_ZERO;
      cyc(14);
      smp();
      chk_bit("pass latched", 1'b0, comma_or_pass_out);
      cyc(1);
      ctl.pattern_test_select <= 1'b0;
      ctl.align_enable <= 1'b0;
      $display("done prbs");
   endtask : t_prbs

   // pattern test through the internal loop: no errors may show
   task automatic t_loop_prbs;
      cyc(1);
      ctl.bus_width_select <= 1'b0;
      ctl.internal_loop_select <= 1'b1;
      ctl.pattern_test_select <= 1'b1;
      cyc(6);
      smp();
      chk_bit("loop pass", 1'b1, comma_or_pass_out);
      chk_bit("serial en", 1'b0, serial_out_en);
      cyc(1);
      ctl.internal_loop_select <= 1'b0;
      ctl.pattern_test_select <= 1'b0;
      $display("done loop prbs");
   endtask : t_loop_prbs

   task automatic t_power;
      rx_amplitude_mv <= 12'h0c8;
      smp();
      chk_bit("signal flag", 1'b1, signal_absent_flag);
      cyc(1);
      rx_amplitude_mv <= 12'h01e;
      smp();
      chk_bit("signal flag", 1'b0, signal_absent_flag);
      cyc(1);
      ctl.enable <= 1'b0;
      ctl.factory_test_select <= 1'b1;
      rx_amplitude_mv <= 12'h0c8;
      tx_data_in <= 10'h3ff;
      smp();
      chk_bit("serial en", 1'b0, serial_out_en);
      chk_bit("factory", 1'b0, factory_test_active);
      chk_word("tx word", WORD_ZERO, tx_word_out);
      chk_bit("signal flag", 1'b0, signal_absent_flag);
      chk_bit("pass off", 1'b0, comma_or_pass_out);
      chk_word("rx word", WORD_ZERO, rx_word_out);
      $display("done power");
   endtask : t_power

   task automatic end_of_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   initial begin
      cyc(5);
      resetn <= 1'b1;
      ctl.enable <= 1'b1;
      smp();
      t_pins();
      t_normal();
      t_loop();
      t_prbs();
      t_loop_prbs();
      t_power();
      end_of_test();
   end

   // the tests need about eighty cycles
   initial begin
      cyc(3000);
      n_fail++;
      end_of_test();
   end
endmodule : tb

`default_nettype wire

// [rtl/pst_pkg.sv]
// constants and carrier types of the pattern self-test block
package pst_pkg;

   localparam int        WORD_W      = 10;
   localparam int        LFSR_W      = 7;
   localparam int        LFSR_TAP_HI = 6;
   localparam int        LFSR_TAP_LO = 5;
   localparam int        MV_W        = 12;
   localparam int        COMMA_W     = 7;
   localparam logic [6:0] LFSR_SEED  = 7'h7f;
   // comma bits 0..6 as received, bit 0 first: 0,0,1,1,1,1,1
   localparam logic [6:0] COMMA_PAT  = 7'h7c;
   localparam logic [9:0] WORD_ZERO  = 10'h000;
   localparam logic [11:0] SIG_HI_MV = 12'h096;
   localparam logic [11:0] SIG_LO_MV = 12'h032;

   typedef struct packed {
      logic enable;
      logic pattern_test_select;
      logic align_enable;
      logic internal_loop_select;
      logic factory_test_select;
      logic bus_width_select;
      logic rx_clock_rate_select;
   } pst_ctl_s;

   typedef enum logic [1:0] {
      CHK_OFF   = 2'b00,
      CHK_PRIME = 2'b01,
      CHK_LIVE  = 2'b10,
      CHK_FAIL  = 2'b11
   } pst_chk_e;

endpackage : pst_pkg

// [rtl/pst_self_test.sv]
// transmit pattern generator, receive checker, loopback and test pin control
`timescale 1ns/1ps
`default_nettype none

module pst_self_test
   import pst_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire pst_ctl_s           ctl,
   input  wire logic [WORD_W-1:0]  tx_data_in,
   input  wire logic [WORD_W-1:0]  rx_word_in,
   input  wire logic [MV_W-1:0]    rx_amplitude_mv,
   input  wire logic               test_reset_n,
   output logic [WORD_W-1:0]       tx_word_out,
   output logic                    serial_out_en,
   output logic [WORD_W-1:0]       rx_word_out,
   output logic                    comma_or_pass_out,
   output logic                    rx_half_rate_out,
   output logic                    signal_absent_flag,
   output logic                    factory_test_active,
   output logic                    scan_tap_in_reset
);

   logic                  en;
   logic                  pts;
   logic [LFSR_W-1:0]     gen_q;
   logic [LFSR_W-1:0]     gen_d;
   logic [WORD_W-1:0]     gen_word;
   logic [LFSR_W-1:0]     chk_q;
   logic [LFSR_W-1:0]     chk_d;
   logic                  word_err;
   logic [WORD_W-1:0]     rx_sel;
   logic                  comma_hit;
   pst_chk_e              state_q;
   pst_chk_e              state_d;
   logic [WORD_W-1:0]     tx_word_q;
   logic [WORD_W-1:0]     rx_word_q;
   logic                  pass_q;
   logic                  pass_d;
   logic                  sig_q;

   assign en  = ctl.enable;
   assign pts = ctl.pattern_test_select;

   // advance generator by one word, bit 0 first
   function automatic logic [LFSR_W+WORD_W-1:0] gen_step(input logic [LFSR_W-1:0] s);
      logic [LFSR_W-1:0] st;
      logic [WORD_W-1:0] w;
      logic              nb;
      st = s;
      w  = WORD_ZERO;
      for (int i = 0; i < WORD_W; i++) begin
         nb   = st[LFSR_TAP_HI] ^ st[LFSR_TAP_LO];
         w[i] = nb;
         st   = {st[LFSR_W-2:0], nb};
      end
      return {st, w};
   endfunction : gen_step

   // check one word; state shifts in received bits so it seeds itself
   function automatic logic [LFSR_W:0] chk_step(input logic [LFSR_W-1:0] s,
                                                input logic [WORD_W-1:0] w);
      logic [LFSR_W-1:0] st;
      logic              e;
      st = s;
      e  = 1'b0;
      for (int i = 0; i < WORD_W; i++) begin
         e  = e | (w[i] != (st[LFSR_TAP_HI] ^ st[LFSR_TAP_LO]));
         st = {st[LFSR_W-2:0], w[i]};
      end
      return {e, st};
   endfunction : chk_step

   assign {gen_d, gen_word} = gen_step(gen_q);
   assign {word_err, chk_d} = chk_step(chk_q, rx_sel);
   assign rx_sel    = ctl.internal_loop_select ? tx_word_q : rx_word_in;
   assign comma_hit = (rx_sel[COMMA_W-1:0] == COMMA_PAT);

   // pattern generator
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gen_q <= LFSR_SEED;
      end else if (!en || !pts) begin
         gen_q <= LFSR_SEED;
      end else begin
         gen_q <= gen_d;
      end
   end

   // transmit word toward the serializer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_word_q <= WORD_ZERO;
      end else if (!en) begin
         tx_word_q <= WORD_ZERO;
      end else if (pts) begin
         tx_word_q <= gen_word;
      end else begin
         tx_word_q <= tx_data_in;
      end
   end

   // received word, from the link or from the loopback path
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_word_q <= WORD_ZERO;
      end else if (!en) begin
         rx_word_q <= WORD_ZERO;
      end else begin
         rx_word_q <= rx_sel;
      end
   end

   // checker history
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         chk_q <= LFSR_SEED;
      end else if (!en) begin
         chk_q <= LFSR_SEED;
      end else begin
         chk_q <= chk_d;
      end
   end

   // checker mode sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CHK_OFF: begin
            if (pts) begin
               state_d = CHK_PRIME;
            end
         end
         CHK_PRIME: begin
            // one seed word; a slower link dips pass at entry
            state_d = CHK_LIVE;
         end
         CHK_LIVE: begin
            if (ctl.align_enable && word_err) begin
               state_d = CHK_FAIL;
            end
         end
         CHK_FAIL: begin
            state_d = CHK_FAIL;
         end
      endcase
      if (!pts) begin
         state_d = CHK_OFF;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= CHK_OFF;
      end else if (!en) begin
         state_q <= CHK_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // shared sync / pass output
   always_comb begin
      pass_d = 1'b1;
      if (!pts) begin
         pass_d = comma_hit;
      end else begin
         unique case (state_q)
            CHK_OFF:   pass_d = 1'b1;
            CHK_PRIME: pass_d = 1'b1;
            CHK_LIVE:  pass_d = !word_err;
            CHK_FAIL:  pass_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pass_q <= 1'b0;
      end else if (!en) begin
         pass_q <= 1'b0;
      end else begin
         pass_q <= pass_d;
      end
   end

   // amplitude flag with undefined band held at last value
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sig_q <= 1'b0;
      end else if (!en) begin
         sig_q <= 1'b0;
      end else if (rx_amplitude_mv > SIG_HI_MV) begin
         sig_q <= 1'b1;
      end else if (rx_amplitude_mv < SIG_LO_MV) begin
         sig_q <= 1'b0;
      end
   end

   assign tx_word_out        = tx_word_q;
   assign rx_word_out        = rx_word_q;
   assign comma_or_pass_out  = pass_q;
   assign signal_absent_flag = sig_q;
   assign serial_out_en      = en && !ctl.internal_loop_select;
   // half rate exists only on the 10-bit bus
   assign rx_half_rate_out   = en && !pts && !ctl.bus_width_select
                               && ctl.rx_clock_rate_select;
   assign factory_test_active = en && ctl.factory_test_select;
   assign scan_tap_in_reset  = !test_reset_n;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_loop_test;
      (en && pts && ctl.internal_loop_select && !ctl.bus_width_select
       && !ctl.align_enable)[*4];
   endsequence

   sequence s_live_err;
      en && pts && state_q == CHK_LIVE && word_err;
   endsequence

   // first enabled cycle of a pattern test
   sequence s_test_entry;
      !pts ##1 (en && pts);
   endsequence

   a_loop_pattern_ok: assert property (s_loop_test |=> comma_or_pass_out)
      else $error("looped pattern reported an error");

   a_tx_input_ignored: assert property (en && pts |=> tx_word_out == $past(gen_word))
      else $error("transmit word not from generator in test");

   a_live_error_low: assert property (s_live_err |=> !comma_or_pass_out)
      else $error("checker error not shown on pass output");

   a_rate_ignored: assert property (pts |-> !rx_half_rate_out)
      else $error("rate select honoured during pattern test");

   a_half_rate_free: assert property (en && !pts && !ctl.bus_width_select
                                      && ctl.rx_clock_rate_select |-> rx_half_rate_out)
      else $error("rate select lost outside pattern test");

   a_entry_pass: assert property (s_test_entry |=> comma_or_pass_out)
      else $error("pass output low while checker seeds");

   a_live_recover: assert property (en && pts && !ctl.align_enable && state_q == CHK_LIVE
                                    && !word_err |=> comma_or_pass_out)
      else $error("live mode pass did not return high");

   a_latch_holds: assert property ((s_live_err and ctl.align_enable) ##1 (en && pts)
                                   |=> !comma_or_pass_out)
      else $error("latched failure released");

   a_fail_sticky: assert property (en && pts && state_q == CHK_FAIL
                                   |=> state_q == CHK_FAIL)
      else $error("latched failure left while test runs");

   a_loop_route: assert property (en && ctl.internal_loop_select
                                  |=> rx_word_out == $past(tx_word_out))
      else $error("loopback word not routed to receiver");

   a_loop_hiz: assert property (ctl.internal_loop_select |-> !serial_out_en)
      else $error("serial driver on during loopback");

   a_power_idle: assert property (!en |=> tx_word_out == WORD_ZERO && !comma_or_pass_out
                                  && rx_word_out == WORD_ZERO)
      else $error("logic active while disabled");

   a_factory_gate: assert property (!ctl.factory_test_select |-> !factory_test_active)
      else $error("factory test active without pin");

   a_signal_flag: assert property (en && rx_amplitude_mv > SIG_HI_MV |=> signal_absent_flag
                                   ##0 $past(rx_amplitude_mv) > SIG_HI_MV)
      else $error("signal flag not set above upper level");

   a_signal_low: assert property (en && rx_amplitude_mv < SIG_LO_MV |=> !signal_absent_flag)
      else $error("signal flag not cleared below lower level");

   a_tap_reset: assert property (!test_reset_n |-> scan_tap_in_reset)
      else $error("scan controller not held in reset");

   a_comma_mark: assert property (en && !pts |=> comma_or_pass_out == $past(comma_hit))
      else $error("comma mark not aligned to word");

endmodule : pst_self_test

`default_nettype wire
